// ---- rtl/ata_cmd_cfg.svh ----
// Register offsets, field positions and reset values of the task file block
`ifndef ATA_CMD_CFG_SVH
`define ATA_CMD_CFG_SVH

// Register byte offsets on the APB side
`define OFF_FEATURES 8'h00
`define OFF_SECTOR_COUNT 8'h04
`define OFF_SECTOR_NUMBER 8'h08
`define OFF_CYL_LOW 8'h0c
`define OFF_CYL_HIGH 8'h10
`define OFF_DRIVE_HEAD 8'h14
`define OFF_COMMAND_CODE 8'h18
`define OFF_DEVICE_CONTROL 8'h1c
`define OFF_DRIVE_ADDRESS 8'h20
`define OFF_TASK_STATUS 8'h24
`define OFF_IRQ_STATUS 8'h28
`define OFF_IRQ_MASK 8'h2c
`define OFF_ACTIVE_COMMAND 8'h30

// Device control fields
`define DC_SOFT_RESET 2
`define DC_INT_DISABLE 1

// Drive/head fields
`define DH_LBA 6
`define DH_DRIVE 4
`define DH_HEAD_MSB 3

// Task status fields
`define TS_BUSY 7
`define TS_READY 6
`define TS_DRQ 3
`define TS_ERR 0

// Interrupt status and mask fields
`define IRQ_DONE 0
`define IRQ_ERROR 1
`define IRQ_REJECT 2
`define IRQ_DRQ 3
`define IRQ_W 4

// Parameter use mask: bit positions and per-command patterns
`define USE_FR 6
`define USE_SC 5
`define USE_SN 4
`define USE_CY 3
`define USE_DR 2
`define USE_HD 1
`define USE_LBA 0
`define USE_NONE 7'h00
`define USE_DR_ONLY 7'h04
`define USE_FULL 7'h3f
`define USE_FORMAT 7'h2f
`define USE_SC_DR 7'h24
`define USE_INIT 7'h26
`define USE_NO_SC 7'h1f
`define USE_FEAT 7'h44
`define USE_WEAR 7'h06

// Task file reset values
`define RST_PARAM 8'h00
`define RST_SECTOR 8'h01
`define RST_DRIVE_HEAD 8'ha0

`endif

// ---- rtl/ata_cmd_pkg.sv ----
// Types shared by the command decoder and the task file block
package ata_cmd_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_SOFT_RESET_BIT = 3'b100
	} ctl_state_t;

	typedef enum logic [4:0] {
		CMD_NONE, CMD_CHECK_POWER, CMD_DIAGNOSTIC, CMD_ERASE, CMD_FORMAT,
		CMD_IDENTIFY, CMD_IDLE, CMD_IDLE_NOW, CMD_INIT_PARAMS, CMD_READ_BUFFER,
		CMD_READ_MULTIPLE, CMD_READ_LONG, CMD_READ_SECTOR, CMD_READ_VERIFY,
		CMD_RECALIBRATE, CMD_REQUEST_SENSE, CMD_SEEK, CMD_SET_FEATURES,
		CMD_SET_MULTIPLE, CMD_SLEEP, CMD_STANDBY, CMD_STANDBY_NOW, CMD_TRANSLATE,
		CMD_WEAR_LEVEL, CMD_WRITE_BUFFER, CMD_WRITE_LONG, CMD_WRITE_MULTIPLE,
		CMD_WRITE_MULT_NOERASE, CMD_WRITE_SECTOR, CMD_WRITE_NOERASE,
		CMD_WRITE_VERIFY
	} cmd_kind_t;

endpackage : ata_cmd_pkg

// ---- rtl/cmd_decode.sv ----
// Command code decoder: operation kind and valid parameter mask
`timescale 1ns/100ps
`include "ata_cmd_cfg.svh"

module cmd_decode (
	input wire logic [7:0] code,
	output ata_cmd_pkg::cmd_kind_t kind,
	output logic [6:0] use_mask,
	output logic known
);

	always_comb
	begin
		casez (code)
			8'he5, 8'h98: kind = ata_cmd_pkg::CMD_CHECK_POWER;
			8'h90: kind = ata_cmd_pkg::CMD_DIAGNOSTIC;
			8'hc0: kind = ata_cmd_pkg::CMD_ERASE;
			8'h50: kind = ata_cmd_pkg::CMD_FORMAT;
			8'hec: kind = ata_cmd_pkg::CMD_IDENTIFY;
			8'he3, 8'h97: kind = ata_cmd_pkg::CMD_IDLE;
			8'he1, 8'h95: kind = ata_cmd_pkg::CMD_IDLE_NOW;
			8'h91: kind = ata_cmd_pkg::CMD_INIT_PARAMS;
			8'he4: kind = ata_cmd_pkg::CMD_READ_BUFFER;
			8'hc4: kind = ata_cmd_pkg::CMD_READ_MULTIPLE;
			8'h22, 8'h23: kind = ata_cmd_pkg::CMD_READ_LONG;
			8'h20, 8'h21: kind = ata_cmd_pkg::CMD_READ_SECTOR;
			8'h40, 8'h41: kind = ata_cmd_pkg::CMD_READ_VERIFY;
			8'h1?: kind = ata_cmd_pkg::CMD_RECALIBRATE;
			8'h03: kind = ata_cmd_pkg::CMD_REQUEST_SENSE;
			8'h7?: kind = ata_cmd_pkg::CMD_SEEK;
			8'hef: kind = ata_cmd_pkg::CMD_SET_FEATURES;
			8'hc6: kind = ata_cmd_pkg::CMD_SET_MULTIPLE;
			8'he6, 8'h99: kind = ata_cmd_pkg::CMD_SLEEP;
			8'he2, 8'h96: kind = ata_cmd_pkg::CMD_STANDBY;
			8'he0, 8'h94: kind = ata_cmd_pkg::CMD_STANDBY_NOW;
			8'h87: kind = ata_cmd_pkg::CMD_TRANSLATE;
			8'hf5: kind = ata_cmd_pkg::CMD_WEAR_LEVEL;
			8'he8: kind = ata_cmd_pkg::CMD_WRITE_BUFFER;
			8'h32, 8'h33: kind = ata_cmd_pkg::CMD_WRITE_LONG;
			8'hc5: kind = ata_cmd_pkg::CMD_WRITE_MULTIPLE;
			8'hcd: kind = ata_cmd_pkg::CMD_WRITE_MULT_NOERASE; // [R04]
			8'h30, 8'h31: kind = ata_cmd_pkg::CMD_WRITE_SECTOR;
			8'h38: kind = ata_cmd_pkg::CMD_WRITE_NOERASE; // [R05]
			8'h3c: kind = ata_cmd_pkg::CMD_WRITE_VERIFY;
			default: kind = ata_cmd_pkg::CMD_NONE; // [R18]
		endcase
	end

	// Which task file parameters each command may consume
	always_comb
	begin
		case (kind)
			ata_cmd_pkg::CMD_ERASE, ata_cmd_pkg::CMD_READ_MULTIPLE,
			ata_cmd_pkg::CMD_READ_SECTOR, ata_cmd_pkg::CMD_READ_VERIFY,
			ata_cmd_pkg::CMD_TRANSLATE, ata_cmd_pkg::CMD_WRITE_MULTIPLE,
			ata_cmd_pkg::CMD_WRITE_MULT_NOERASE, ata_cmd_pkg::CMD_WRITE_SECTOR,
			ata_cmd_pkg::CMD_WRITE_NOERASE, ata_cmd_pkg::CMD_WRITE_VERIFY:
				use_mask = `USE_FULL; // [R03] [R04] [R05]
			ata_cmd_pkg::CMD_FORMAT: use_mask = `USE_FORMAT; // [R03]
			ata_cmd_pkg::CMD_IDLE, ata_cmd_pkg::CMD_SET_MULTIPLE: use_mask = `USE_SC_DR;
			ata_cmd_pkg::CMD_INIT_PARAMS: use_mask = `USE_INIT;
			ata_cmd_pkg::CMD_READ_LONG, ata_cmd_pkg::CMD_SEEK,
			ata_cmd_pkg::CMD_WRITE_LONG: use_mask = `USE_NO_SC;
			ata_cmd_pkg::CMD_SET_FEATURES: use_mask = `USE_FEAT;
			ata_cmd_pkg::CMD_WEAR_LEVEL: use_mask = `USE_WEAR;
			ata_cmd_pkg::CMD_NONE: use_mask = `USE_NONE;
			default: use_mask = `USE_DR_ONLY;
		endcase
	end

	assign known = (kind != ata_cmd_pkg::CMD_NONE);

endmodule : cmd_decode

// ---- rtl/ata_cmd_ctrl.sv ----
// Task file, command issue, device control and drive address block on APB
//
// What this block does
// [R01] Command code is write-only; writing it starts the decoded drive operation.
// [R02] Host loads parameters first, then writes the command while ready.
// [R03] Each command passes on only its valid parameters; others are zeroed.
// [R04] Code CDH decodes as multiple-sector write without erase, full parameters.
// [R05] Code 38H decodes as sector write without erase, full parameters.
// [R06] Device control is write-only; holds soft reset and interrupt gate.
// [R07] Host writes bit 3 one, bit 0 zero; bits 7 to 4 ignored.
// [R08] Soft reset bit 2 written one performs a task file reset.
// [R09] Soft reset leaves configuration registers untouched.
// [R10] Block stays in reset while the soft reset bit remains one.
// [R11] Device control bit 1 at one suppresses the interrupt request output.
// [R12] Read-only drive address register reports drive status.
// [R13] Drive address bits 5 to 2 return inverted head bits; others zero.
// [R14] Host should avoid mapping the drive address register.
// [R15] Head number is the low four bits of drive/head, bit 3 MSB.
// [R16] Error flag sets on failed command, clears on next command.
// [R17] Data request flag clears when another command is written.
// [R18] All listed codes decode; unknown codes end with error flag set.
// [R19] Commands written while busy are ignored; parameters sampled at command write.
`timescale 1ns/100ps
`include "ata_cmd_cfg.svh"

module ata_cmd_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_done,
	input wire logic op_error,
	input wire logic op_data_request,
	output logic op_start,
	output ata_cmd_pkg::cmd_kind_t op_kind,
	output logic [7:0] op_features,
	output logic [7:0] op_sector_count,
	output logic [7:0] op_sector_number,
	output logic [15:0] op_cylinder,
	output logic op_drive_select,
	output logic [3:0] op_head,
	output logic op_lba_mode,
	output logic soft_reset_active,
	output logic interrupt_request_out_n,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction : hit
	function automatic logic [7:0] pick(input logic en, input logic [7:0] value);
		pick = en ? value : `RST_PARAM;
	endfunction : pick
	////////////////////////////////////////////////////////////////////////////////
	// Storage
	ata_cmd_pkg::ctl_state_t state;
	logic [7:0] features, sector_count, sector_number, cylinder_low, cylinder_high;
	logic [7:0] drive_head, active_command;
	logic soft_reset_bit, interrupt_disable_bit, error_flag, data_request_flag, ata_pending;
	logic [`IRQ_W-1:0] irq_status, irq_mask;
	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	logic access, wr_fire, rd_fire, addr_ok, lane0, param_open, cmd_write, accept, reject;
	logic start_op, busy_done, in_idle, in_busy, in_soft_reset_bit, pending_set, pending_clear;
	logic [7:0] drive_address_status, task_status;
	logic [31:0] read_value;
	ata_cmd_pkg::cmd_kind_t dec_kind;
	logic [6:0] dec_use;
	logic dec_known;
	logic [`IRQ_W-1:0] irq_events, irq_clear;

	assign access = psel & penable;
	assign wr_fire = access & pready & pwrite;
	assign rd_fire = access & pready & ~pwrite;
	assign lane0 = pstrb[0];
	assign in_idle = (state == ata_cmd_pkg::ST_IDLE);
	assign in_busy = (state == ata_cmd_pkg::ST_BUSY);
	assign in_soft_reset_bit = (state == ata_cmd_pkg::ST_SOFT_RESET_BIT);
	assign busy_done = in_busy & op_done;
	// Frozen while busy so a running operation sees stable values
	assign param_open = wr_fire & lane0 & in_idle & ~soft_reset_bit;
	assign cmd_write = wr_fire & lane0 & hit(paddr, `OFF_COMMAND_CODE); // [R01]
	assign accept = cmd_write & in_idle & ~soft_reset_bit; // [R19]
	assign reject = cmd_write & ~(in_idle & ~soft_reset_bit); // [R19]
	assign start_op = accept & dec_known; // [R01] [R18]
	always_comb
	begin
		addr_ok = 1'b0;
		case (paddr)
			`OFF_FEATURES, `OFF_SECTOR_COUNT, `OFF_SECTOR_NUMBER, `OFF_CYL_LOW,
			`OFF_CYL_HIGH, `OFF_DRIVE_HEAD, `OFF_COMMAND_CODE, `OFF_DEVICE_CONTROL,
			`OFF_DRIVE_ADDRESS, `OFF_TASK_STATUS, `OFF_IRQ_STATUS, `OFF_IRQ_MASK,
			`OFF_ACTIVE_COMMAND: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	// Only the head field has a source
	assign drive_address_status = {2'b00, ~drive_head[`DH_HEAD_MSB:0], 2'b00}; // [R12] [R13]
	always_comb
	begin
		task_status = 8'h00;
		task_status[`TS_BUSY] = in_busy | in_soft_reset_bit;
		task_status[`TS_READY] = in_idle;
		task_status[`TS_DRQ] = data_request_flag;
		task_status[`TS_ERR] = error_flag;
	end
	// Write-only registers read as zero
	always_comb
	begin
		read_value = 32'h00000000;
		case (paddr)
			`OFF_FEATURES: read_value[7:0] = features;
			`OFF_SECTOR_COUNT: read_value[7:0] = sector_count;
			`OFF_SECTOR_NUMBER: read_value[7:0] = sector_number;
			`OFF_CYL_LOW: read_value[7:0] = cylinder_low;
			`OFF_CYL_HIGH: read_value[7:0] = cylinder_high;
			`OFF_DRIVE_HEAD: read_value[7:0] = drive_head;
			`OFF_DRIVE_ADDRESS: read_value[7:0] = drive_address_status; // [R12]
			`OFF_TASK_STATUS: read_value[7:0] = task_status;
			`OFF_IRQ_STATUS: read_value[`IRQ_W-1:0] = irq_status;
			`OFF_IRQ_MASK: read_value[`IRQ_W-1:0] = irq_mask;
			`OFF_ACTIVE_COMMAND: read_value[7:0] = active_command;
			default: read_value = 32'h00000000;
		endcase
	end
	cmd_decode u_decode (
		.code(pwdata[7:0]),
		.kind(dec_kind),
		.use_mask(dec_use),
		.known(dec_known)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB response: one wait state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= access & ~pready;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (access & ~pready)
		begin
			prdata <= pwrite ? 32'h00000000 : read_value;
			pslverr <= ~addr_ok;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Device control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			soft_reset_bit <= 1'b0;
			interrupt_disable_bit <= 1'b0;
		end
		else if (wr_fire & lane0 & hit(paddr, `OFF_DEVICE_CONTROL))
		begin
			// Other bits are dropped
			soft_reset_bit <= pwdata[`DC_SOFT_RESET]; // [R06] [R07] [R08]
			interrupt_disable_bit <= pwdata[`DC_INT_DISABLE]; // [R06] [R11]
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Control state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ata_cmd_pkg::ST_IDLE;
		else
		begin
			case (state)
				ata_cmd_pkg::ST_IDLE:
					if (soft_reset_bit)
						state <= ata_cmd_pkg::ST_SOFT_RESET_BIT; // [R08]
					else if (start_op)
						state <= ata_cmd_pkg::ST_BUSY; // [R01]
				ata_cmd_pkg::ST_BUSY:
					if (soft_reset_bit)
						state <= ata_cmd_pkg::ST_SOFT_RESET_BIT; // [R08]
					else if (op_done)
						state <= ata_cmd_pkg::ST_IDLE;
				ata_cmd_pkg::ST_SOFT_RESET_BIT:
					if (!soft_reset_bit)
						state <= ata_cmd_pkg::ST_IDLE; // [R10]
				default: state <= ata_cmd_pkg::ST_IDLE;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			soft_reset_active <= 1'b0;
		else
			soft_reset_active <= soft_reset_bit; // [R10]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Task file parameters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			features <= `RST_PARAM;
			sector_count <= `RST_SECTOR;
			sector_number <= `RST_SECTOR;
			cylinder_low <= `RST_PARAM;
			cylinder_high <= `RST_PARAM;
			drive_head <= `RST_DRIVE_HEAD;
		end
		else if (in_soft_reset_bit)
		begin
			features <= `RST_PARAM; // [R08]
			sector_count <= `RST_SECTOR;
			sector_number <= `RST_SECTOR;
			cylinder_low <= `RST_PARAM;
			cylinder_high <= `RST_PARAM;
			drive_head <= `RST_DRIVE_HEAD;
		end
		else if (param_open)
		begin
			if (hit(paddr, `OFF_FEATURES))
				features <= pwdata[7:0];
			if (hit(paddr, `OFF_SECTOR_COUNT))
				sector_count <= pwdata[7:0];
			if (hit(paddr, `OFF_SECTOR_NUMBER))
				sector_number <= pwdata[7:0];
			if (hit(paddr, `OFF_CYL_LOW))
				cylinder_low <= pwdata[7:0];
			if (hit(paddr, `OFF_CYL_HIGH))
				cylinder_high <= pwdata[7:0];
			if (hit(paddr, `OFF_DRIVE_HEAD))
				drive_head <= pwdata[7:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Command issue: parameters latched at the command write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			op_start <= 1'b0;
		else
			op_start <= start_op; // [R01]
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_kind <= ata_cmd_pkg::CMD_NONE;
			op_features <= `RST_PARAM;
			op_sector_count <= `RST_PARAM;
			op_sector_number <= `RST_PARAM;
			op_cylinder <= {`RST_PARAM, `RST_PARAM};
			op_drive_select <= 1'b0;
			op_head <= 4'h0;
			op_lba_mode <= 1'b0;
		end
		else if (start_op)
		begin
			op_kind <= dec_kind; // [R04] [R05] [R18]
			op_features <= pick(dec_use[`USE_FR], features); // [R03] [R19]
			op_sector_count <= pick(dec_use[`USE_SC], sector_count); // [R03]
			op_sector_number <= pick(dec_use[`USE_SN], sector_number); // [R03]
			op_cylinder <= {pick(dec_use[`USE_CY], cylinder_high),
				pick(dec_use[`USE_CY], cylinder_low)}; // [R03]
			op_drive_select <= dec_use[`USE_DR] & drive_head[`DH_DRIVE]; // [R03]
			op_head <= dec_use[`USE_HD] ? drive_head[`DH_HEAD_MSB:0] : 4'h0; // [R03] [R15]
			op_lba_mode <= dec_use[`USE_LBA] & drive_head[`DH_LBA]; // [R03]
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			active_command <= `RST_PARAM;
		else if (accept)
			active_command <= pwdata[7:0];
	end
	////////////////////////////////////////////////////////////////////////////////
	// Status flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			error_flag <= 1'b0;
		else if (in_soft_reset_bit)
			error_flag <= 1'b0;
		else if (accept)
			error_flag <= ~dec_known; // [R16] [R18]
		else if (busy_done & op_error)
			error_flag <= 1'b1; // [R16]
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_request_flag <= 1'b0;
		else if (in_soft_reset_bit | accept | busy_done)
			data_request_flag <= 1'b0; // [R17]
		else if (in_busy & op_data_request)
			data_request_flag <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Host interrupt: status read acknowledges, new events win
	assign pending_set = busy_done | (accept & ~dec_known) | (in_busy & op_data_request);
	assign pending_clear = in_soft_reset_bit | accept | (rd_fire & hit(paddr, `OFF_TASK_STATUS));
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ata_pending <= 1'b0;
		else
			ata_pending <= pending_set | (ata_pending & ~pending_clear);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			interrupt_request_out_n <= 1'b1;
		else
			interrupt_request_out_n <= ~(ata_pending & ~interrupt_disable_bit); // [R11]
	end
	////////////////////////////////////////////////////////////////////////////////
	// System interrupt: sticky status, write one to clear, set beats clear
	// Kept across soft reset
	always_comb
	begin
		irq_events = '0;
		irq_events[`IRQ_DONE] = busy_done;
		irq_events[`IRQ_ERROR] = (busy_done & op_error) | (accept & ~dec_known);
		irq_events[`IRQ_REJECT] = reject;
		irq_events[`IRQ_DRQ] = in_busy & op_data_request;
	end
	assign irq_clear = (wr_fire & lane0 & hit(paddr, `OFF_IRQ_STATUS)) ? pwdata[`IRQ_W-1:0] : '0;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status <= '0;
		else
			irq_status <= irq_events | (irq_status & ~irq_clear); // [R09]
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask <= '0;
		else if (wr_fire & lane0 & hit(paddr, `OFF_IRQ_MASK))
			irq_mask <= pwdata[`IRQ_W-1:0]; // [R09]
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end
endmodule : ata_cmd_ctrl

// ---- verif/op_backend_model.sv ----
// Behavioural back end that answers every started drive operation
`timescale 1ns/100ps

module op_backend_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic op_start,
	input wire logic [7:0] wait_cycles,
	input wire logic fail,
	input wire logic want_data,
	output logic op_done,
	output logic op_error,
	output logic op_data_request
);
	logic [7:0] left;
	logic running;

	// Error shows the inverse outside done
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			running <= 1'h0;
			left <= 8'h00;
			op_done <= 1'h0;
			op_error <= 1'h0;
			op_data_request <= 1'h0;
		end
		else
		begin
			op_done <= running && left == 8'h00;
			op_error <= (running && left == 8'h00) ? fail : !fail;
			op_data_request <= running && want_data && left == 8'h02;
			if (op_start)
				running <= 1'h1;
			else if (left == 8'h00)
				running <= 1'h0;
			if (op_start)
				left <= wait_cycles;
			else if (running && left != 8'h00)
				left <= left - 8'h01;
		end
	end
endmodule : op_backend_model

// ---- verif/ata_cmd_ctrl_chk.sv ----
// Port assertions and bind for the task file block
`timescale 1ns/100ps
`include "ata_cmd_cfg.svh"

module ata_cmd_ctrl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic op_start,
	input wire ata_cmd_pkg::cmd_kind_t op_kind,
	input wire logic soft_reset_active,
	input wire logic interrupt_request_out_n
);
	logic wr_done, dc_write, soft_reset_bit_set, soft_reset_bit_clr, irq_off;

	assign wr_done = psel && penable && pready && pwrite;
	assign dc_write = wr_done && paddr == `OFF_DEVICE_CONTROL;
	assign soft_reset_bit_set = dc_write && pwdata[`DC_SOFT_RESET];
	assign soft_reset_bit_clr = dc_write && !pwdata[`DC_SOFT_RESET];

	// Disable bit is write-only, so track it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_off <= 1'h0;
		else if (dc_write)
			irq_off <= pwdata[`DC_INT_DISABLE];
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	wait_state_a: assert property (psel && penable && !pready |=> pready)
		else $error("late pready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("long pready");
	mapped_ok_a: assert property (pready && paddr <= `OFF_ACTIVE_COMMAND && paddr[1:0] == 2'h0
		|-> !pslverr)
		else $error("error on mapped");
	start_cause_a: assert property (op_start |-> $past(wr_done && paddr == `OFF_COMMAND_CODE))
		else $error("stray start");
	start_pulse_a: assert property (op_start |=> !op_start)
		else $error("long start");
	start_soft_reset_bit_a: assert property (op_start |-> !$past(soft_reset_active))
		else $error("start in reset");
	soft_reset_bit_rise_a: assert property ($rose(soft_reset_active) |-> $past(soft_reset_bit_set) || $past(soft_reset_bit_set, 2))
		else $error("stray reset entry");
	soft_reset_bit_fall_a: assert property ($fell(soft_reset_active) |-> $past(soft_reset_bit_clr) || $past(soft_reset_bit_clr, 2))
		else $error("stray reset exit");
	irq_gate_a: assert property (irq_off && $past(irq_off) |-> interrupt_request_out_n)
		else $error("request while disabled");
	kind_hold_a: assert property (!op_start |-> $stable(op_kind))
		else $error("kind changed");
	rdata_hold_a: assert property (!pready |-> $stable(prdata))
		else $error("read data moved");

	cover property (op_start);
	cover property ($rose(soft_reset_active));
	cover property (pslverr);
endmodule : ata_cmd_ctrl_chk

bind ata_cmd_ctrl ata_cmd_ctrl_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .op_start(op_start), .op_kind(op_kind),
	.soft_reset_active(soft_reset_active), .interrupt_request_out_n(interrupt_request_out_n));

// ---- verif/ata_cmd_ctrl_tb_top.sv ----
// Self-checking bench for the task file block
`timescale 1ns/100ps
`include "ata_cmd_cfg.svh"

module ata_cmd_ctrl_tb_top;
	typedef struct packed {
		logic [7:0] code;
		ata_cmd_pkg::cmd_kind_t kind;
		logic [6:0] use_mask;
	} cmd_case_t;

	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, fail = 1'h0;
	logic [7:0] paddr = 8'h00, wait_cycles = 8'h04;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, op_done, op_error, op_data_request, op_start, last_err;
	logic op_drive_select, op_lba_mode, soft_reset_active, interrupt_request_out_n, irq;
	ata_cmd_pkg::cmd_kind_t op_kind;
	logic [7:0] op_features, op_sector_count, op_sector_number;
	logic [15:0] op_cylinder;
	logic [3:0] op_head;
	int checks = 0, bad_count = 0, starts = 0, i, s;
	cmd_case_t cases [11] = '{
		'{8'hcd, ata_cmd_pkg::CMD_WRITE_MULT_NOERASE, `USE_FULL},
		'{8'h38, ata_cmd_pkg::CMD_WRITE_NOERASE, `USE_FULL},
		'{8'h98, ata_cmd_pkg::CMD_CHECK_POWER, `USE_DR_ONLY},
		'{8'h50, ata_cmd_pkg::CMD_FORMAT, `USE_FORMAT},
		'{8'h97, ata_cmd_pkg::CMD_IDLE, `USE_SC_DR},
		'{8'h91, ata_cmd_pkg::CMD_INIT_PARAMS, `USE_INIT},
		'{8'h23, ata_cmd_pkg::CMD_READ_LONG, `USE_NO_SC},
		'{8'hef, ata_cmd_pkg::CMD_SET_FEATURES, `USE_FEAT},
		'{8'hf5, ata_cmd_pkg::CMD_WEAR_LEVEL, `USE_WEAR},
		'{8'h1a, ata_cmd_pkg::CMD_RECALIBRATE, `USE_DR_ONLY},
		'{8'h7c, ata_cmd_pkg::CMD_SEEK, `USE_NO_SC}};

	always #50 pclk = ~pclk;

	always @(posedge pclk)
		starts <= starts + int'(op_start === 1'h1);

	ata_cmd_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .op_done(op_done), .op_error(op_error),
		.op_data_request(op_data_request), .op_start(op_start), .op_kind(op_kind),
		.op_features(op_features), .op_sector_count(op_sector_count),
		.op_sector_number(op_sector_number), .op_cylinder(op_cylinder),
		.op_drive_select(op_drive_select), .op_head(op_head), .op_lba_mode(op_lba_mode),
		.soft_reset_active(soft_reset_active), .interrupt_request_out_n(interrupt_request_out_n),
		.irq(irq));

	op_backend_model backend (.pclk(pclk), .presetn(presetn), .op_start(op_start),
		.wait_cycles(wait_cycles), .fail(fail), .want_data(1'h1), .op_done(op_done),
		.op_error(op_error), .op_data_request(op_data_request));

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic give_up();
		bad_count++;
		wrap_up();
	endtask : give_up

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_bit(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask : chk_bit

	// An idle cycle separates transfers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (n = 0; n < 20 && pready !== 1'h1; n++)
			@(posedge pclk);
		q = prdata;
		last_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1)
			give_up();
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'h1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'h0, a, 32'h0, q);
		chk_reg(q, exp);
	endtask : rd

	task automatic settle();
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	task automatic wait_done(output logic [31:0] q);
		int n;
		q = 32'h0;
		for (n = 0; n < 60 && q[`IRQ_DONE] !== 1'h1; n++)
			apb(1'h0, `OFF_IRQ_STATUS, 32'h0, q);
		if (q[`IRQ_DONE] !== 1'h1)
			give_up();
	endtask : wait_done

	task automatic load();
		wr(`OFF_FEATURES, 32'h11);
		wr(`OFF_SECTOR_COUNT, 32'h22);
		wr(`OFF_SECTOR_NUMBER, 32'h33);
		wr(`OFF_CYL_LOW, 32'h55);
		wr(`OFF_CYL_HIGH, 32'h44);
		wr(`OFF_DRIVE_HEAD, 32'hf7);
	endtask : load

	task automatic issue(input cmd_case_t c);
		int n;
		logic [6:0] u;
		logic [31:0] e1, e2, q;
		n = starts;
		u = c.use_mask;
		e1 = {u[`USE_FR] ? 8'h11 : 8'h00, u[`USE_SC] ? 8'h22 : 8'h00, u[`USE_SN] ? 8'h33 : 8'h00,
			3'h0, c.kind};
		e2 = {u[`USE_CY] ? 16'h4455 : 16'h0000, 10'h0, u[`USE_DR], u[`USE_HD] ? 4'h7 : 4'h0,
			u[`USE_LBA]};
		wr(`OFF_COMMAND_CODE, {24'h0, c.code});
		settle();
		chk_reg(32'(starts - n), 32'h1);
		chk_reg({op_features, op_sector_count, op_sector_number, 3'h0, op_kind}, e1);
		chk_reg({op_cylinder, 10'h0, op_drive_select, op_head, op_lba_mode}, e2);
		wait_done(q);
		chk_reg(q, {29'h1, 1'h0, fail, 1'h1});
		chk_bit(irq, 1'h1);
		chk_bit(interrupt_request_out_n, 1'h0);
		apb(1'h0, `OFF_TASK_STATUS, 32'h0, q);
		chk_reg(q & 32'hc9, {25'h0, 1'h1, 5'h0, fail});
		wr(`OFF_IRQ_STATUS, 32'hf);
		settle();
		chk_bit(irq, 1'h0);
		chk_bit(interrupt_request_out_n, 1'h1);
	endtask : issue

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		rd(`OFF_SECTOR_NUMBER, 32'h1);
		rd(`OFF_DRIVE_ADDRESS, 32'h3c);
		rd(`OFF_COMMAND_CODE, 32'h0);
		rd(`OFF_DEVICE_CONTROL, 32'h0);
		rd(8'h40, 32'h0);
		chk_bit(last_err, 1'h1);
		wr(`OFF_DRIVE_ADDRESS, 32'hff);
		rd(`OFF_DRIVE_ADDRESS, 32'h3c);
		load();
		rd(`OFF_DRIVE_ADDRESS, 32'h20);
		wr(`OFF_IRQ_MASK, 32'h1);
		for (i = 0; i < 11; i++)
		begin
			fail <= 1'(i == 2);
			issue(cases[i]);
		end
		s = starts;
		wr(`OFF_COMMAND_CODE, 32'hff);
		settle();
		chk_reg(32'(starts - s), 32'h0);
		rd(`OFF_IRQ_STATUS, 32'h2);
		chk_bit(irq, 1'h0);
		chk_bit(interrupt_request_out_n, 1'h0);
		wr(`OFF_DEVICE_CONTROL, 32'h0a);
		settle();
		chk_bit(interrupt_request_out_n, 1'h1);
		wr(`OFF_DEVICE_CONTROL, 32'h08);
		apb(1'h0, `OFF_TASK_STATUS, 32'h0, r);
		chk_reg(r & 32'h1, 32'h1);
		wr(`OFF_IRQ_STATUS, 32'hf);
		wait_cycles <= 8'h28;
		s = starts;
		wr(`OFF_COMMAND_CODE, 32'h20);
		wr(`OFF_FEATURES, 32'h99);
		wr(`OFF_COMMAND_CODE, 32'h30);
		rd(`OFF_IRQ_STATUS, 32'h4);
		chk_reg(32'(starts - s), 32'h1);
		wait_done(r);
		rd(`OFF_FEATURES, 32'h11);
		wait_cycles <= 8'h04;
		wr(`OFF_IRQ_MASK, 32'h5);
		wr(`OFF_DEVICE_CONTROL, 32'h0c);
		settle();
		chk_bit(soft_reset_active, 1'h1);
		rd(`OFF_FEATURES, 32'h0);
		rd(`OFF_DRIVE_HEAD, 32'ha0);
		s = starts;
		wr(`OFF_COMMAND_CODE, 32'h20);
		settle();
		chk_reg(32'(starts - s), 32'h0);
		rd(`OFF_IRQ_MASK, 32'h5);
		wr(`OFF_DEVICE_CONTROL, 32'hf8);
		settle();
		chk_bit(soft_reset_active, 1'h0);
		wr(`OFF_IRQ_MASK, 32'h1);
		wr(`OFF_IRQ_STATUS, 32'hf);
		load();
		issue(cases[1]);
		wrap_up();
	end
endmodule : ata_cmd_ctrl_tb_top
